// *** common/pr_cfg.svh ***
// Offsets, field positions, reset values and timing counts of the pattern register block
`ifndef PR_CFG_SVH
`define PR_CFG_SVH
// ****************************************************************
// Mode register numbers and fields
// ****************************************************************
`define PR_MR0           3'h0
`define PR_MR3           3'h3
`define PR_MR5           3'h5
`define PR_MR3_MODE_BIT  2
`define PR_MR3_PAGE_LSB  0
`define PR_MR3_FMT_LSB   11
`define PR_MR0_BL_LSB    0
`define PR_MR5_PL_LSB    0
`define PR_A12_BIT       12
`define PR_A10_BIT       10
`define PR_BL_OTF        2'h1
`define PR_BL_BC4        2'h2
`define PR_PAGE0         2'h0
// ****************************************************************
// Reset values
// ****************************************************************
`define PR_PAT_RST       8'h00
`define PR_MR3_RST       13'h0000
// ****************************************************************
// Timing (ns as printed by the part, cycles derived at 10 ns)
// ****************************************************************
`define PR_CLK_NS        10
`define PR_CYC(ns)       (((ns) + `PR_CLK_NS - 1) / `PR_CLK_NS)
`define PR_T_RP_NS       15
`define PR_T_MRD_NS      10
`define PR_T_MOD_NS      30
`define PR_T_WR_PAT_NS   40
`define PR_T_EXIT_NS     20
`define PR_T_RP_CYC      8'(`PR_CYC(`PR_T_RP_NS))
`define PR_T_MRD_CYC     8'(`PR_CYC(`PR_T_MRD_NS))
`define PR_T_MOD_CYC     8'(`PR_CYC(`PR_T_MOD_NS))
`define PR_T_WR_PAT_CYC  8'(`PR_CYC(`PR_T_WR_PAT_NS))
`define PR_T_EXIT_CYC    8'(`PR_CYC(`PR_T_EXIT_NS))
`define PR_READ_LAT      4'h4
`define PR_BURST_GAP     8'h07
`define PR_REF_GAP       8'h07
`define PR_LANES         16
`define PR_PIPE_DEPTH    12
`endif

// *** common/pr_if.sv ***
// Command and data link between controller and pattern register logic
`default_nettype none
interface pr_if;
	import pr_pkg::*;
	logic          cmd_valid;
	pr_cmd_e       cmd;
	logic  [1:0]   bg;
	logic  [1:0]   ba;
	logic  [17:0]  addr;
	logic          dbi_n;
	logic  [15:0]  dq;
	logic          dq_valid;
	modport dram (input cmd_valid, cmd, bg, ba, addr, dbi_n, output dq, dq_valid);
	modport ctrl (output cmd_valid, cmd, bg, ba, addr, dbi_n, input dq, dq_valid);
endinterface
`default_nettype wire

// *** common/pr_pkg.sv ***
// Types shared by both ends of the pattern register link
`default_nettype none
package pr_pkg;
	typedef enum logic [2:0] {
		PR_NOP = 3'h0,
		PR_MRS = 3'h1,
		PR_REF = 3'h2,
		PR_PRE = 3'h3,
		PR_ACT = 3'h4,
		PR_RD  = 3'h5,
		PR_WR  = 3'h6
	} pr_cmd_e;
	typedef enum logic [1:0] {
		PR_SERIAL   = 2'h0,
		PR_PARALLEL = 2'h1,
		PR_STAGGER  = 2'h2,
		PR_FMT_RFU  = 2'h3
	} pr_fmt_e;
	typedef enum logic [5:0] {
		H_IDLE = 6'h01,
		H_PRE  = 6'h02,
		H_MRS  = 6'h04,
		H_ACC  = 6'h08,
		H_WAIT = 6'h10,
		H_EXIT = 6'h20
	} pr_hstate_e;
endpackage
`default_nettype wire

// *** hdl/pr_ctrl.sv ***
// Controller end: pattern mode entry, accesses, refresh and exit
`default_nettype none
`include "pr_cfg.svh"
module pr_ctrl
	import pr_pkg::*;
(
	// Clock and reset
	input  wire logic    sys_clk,
	input  wire logic    rst,
	// Link to device
	pr_if.ctrl           link,
	// Session setup
	input  wire logic    dll_locked,
	input  wire pr_fmt_e req_fmt,
	input  wire logic [1:0] bl_field,
	input  wire logic [2:0] pl_code,
	// Requests
	input  wire logic    req_valid,
	input  wire logic    req_write,
	input  wire logic [1:0] req_loc,
	input  wire logic [7:0] req_data,
	input  wire logic    ref_req,
	input  wire logic    exit_req,
	output logic         req_ready,
	// Read return and busy status
	output logic         rd_valid,
	output logic [127:0] rd_data,
	output logic         busy
);
	pr_hstate_e  st;
	logic [7:0]  wait_cnt;
	logic [1:0]  mrs_idx;
	logic        ref_pend;
	logic        go;
	logic        take_ref;
	logic [2:0]  rbeat;

	assign go       = wait_cnt == 8'h00;
	assign take_ref = st == H_ACC && go && ref_pend;

	// Refresh request latch; a new request beats the clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ref_pend <= 1'b0;
		end else if (ref_req) begin
			ref_pend <= 1'b1;
		end else if (take_ref) begin
			ref_pend <= 1'b0;
		end
	end

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st             <= H_IDLE;
			wait_cnt       <= 8'h00;
			mrs_idx        <= 2'h0;
			req_ready      <= 1'b0;
			busy           <= 1'b0;
			link.cmd_valid <= 1'b0;
			link.cmd       <= PR_NOP;
			link.bg        <= 2'h0;
			link.ba        <= 2'h0;
			link.addr      <= 18'h00000;
			link.dbi_n     <= 1'b1;
		end else begin
			link.cmd_valid <= 1'b0;
			link.dbi_n     <= 1'b1;
			req_ready      <= 1'b0;
			busy           <= st != H_IDLE;
			if (!go) begin
				wait_cnt <= wait_cnt - 8'h01;
			end
			case (st)
				H_IDLE: if (req_valid && dll_locked) begin
					link.cmd_valid <= 1'b1;
					link.cmd       <= PR_PRE;
					link.addr      <= 18'h00000;
					link.addr[`PR_A10_BIT] <= 1'b1;
					wait_cnt       <= `PR_T_RP_CYC;
					st             <= H_PRE;
				end
				H_PRE: if (go) begin
					mrs_idx <= 2'h0;
					st      <= H_MRS;
				end
				// Burst field, parity latency, then the mode bit with page 0
				H_MRS: if (go) begin
					link.cmd_valid <= 1'b1;
					link.cmd       <= PR_MRS;
					link.addr      <= 18'h00000;
					mrs_idx        <= mrs_idx + 2'h1;
					wait_cnt       <= `PR_T_MRD_CYC;
					case (mrs_idx)
						2'h0: begin
							{link.bg[0], link.ba} <= `PR_MR0;
							link.addr[`PR_MR0_BL_LSB +: 2] <= bl_field;
						end
						2'h1: begin
							{link.bg[0], link.ba} <= `PR_MR5;
							link.addr[`PR_MR5_PL_LSB +: 3] <= pl_code;
						end
						default: begin
							{link.bg[0], link.ba} <= `PR_MR3;
							link.addr[`PR_MR3_MODE_BIT] <= 1'b1;
							link.addr[`PR_MR3_PAGE_LSB +: 2] <= `PR_PAGE0;
							link.addr[`PR_MR3_FMT_LSB +: 2] <= req_fmt;
							wait_cnt <= `PR_T_MOD_CYC;
							st       <= H_ACC;
						end
					endcase
				end
				H_ACC: if (go) begin
					link.bg   <= 2'h0;
					link.addr <= 18'h00000;
					if (ref_pend) begin
						link.cmd_valid <= 1'b1;
						link.cmd       <= PR_REF;
						wait_cnt       <= `PR_REF_GAP;
					end else if (req_valid) begin
						link.cmd_valid <= 1'b1;
						link.ba        <= req_loc;
						req_ready      <= 1'b1;
						if (req_write) begin
							link.cmd       <= PR_WR;
							link.addr[7:0] <= req_data;
							wait_cnt       <= `PR_T_WR_PAT_CYC;
						end else begin
							link.cmd <= PR_RD;
							link.addr[`PR_A12_BIT] <= bl_field == `PR_BL_OTF;
							wait_cnt <= `PR_BURST_GAP;
						end
					end else if (exit_req) begin
						wait_cnt <= `PR_T_EXIT_CYC;
						st       <= H_WAIT;
					end
				end
				H_WAIT: if (go) begin
					link.cmd_valid <= 1'b1;
					link.cmd       <= PR_MRS;
					{link.bg[0], link.ba} <= `PR_MR3;
					link.addr      <= 18'h00000;
					wait_cnt       <= `PR_T_MOD_CYC;
					st             <= H_EXIT;
				end
				H_EXIT: if (go) begin
					st <= H_IDLE;
				end
				default: st <= H_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Read capture
	// ****************************************************************
	// Beats stack low to high; beat 7 completes the word
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rbeat    <= 3'h0;
			rd_valid <= 1'b0;
			rd_data  <= '0;
		end else begin
			rd_valid <= link.dq_valid && rbeat == 3'h7;
			if (link.dq_valid) begin
				rd_data[{rbeat, 4'h0} +: 16] <= link.dq;
				rbeat <= rbeat + 3'h1;
			end
		end
	end
endmodule
`default_nettype wire

// *** hdl/pr_dram.sv ***
// Device end: pattern register storage, mode control and read bursts
// Functional notes
// - x4 stagger: lane i carries location k+i mod 4
// - x8 upper nibble repeats lower nibble mapping
// - x16 upper byte repeats lower byte mapping
// - Back-to-back reads give gapless contiguous bursts
// - Controller reads with A[2:0] zero, BL8 or BC4
// - Controller sets A12 when burst field is 01
// - BA1:BA0 select pattern location 0 to 3
// - A10, BG and unused address ignored
// - Parity latency adds to read data delay
// - Write stores A[7:0] as beats 7:0
// - Controller never uses DBI on pattern writes
// - Written values held until reset
// - Controller waits for DLL lock first
// - Controller precharges all, waits row precharge time
// - Controller enters with mode bit, page 0
// - Controller waits write recovery after each write
// - Controller waits exit time before leaving
// - Exit clears mode bit; core after delay
// - Mode bit redirects reads and writes here
// - Only 1x refresh while pattern mode on
// - Format field: serial, parallel, stagger, reserved
// - Serial format: same byte on every lane
`default_nettype none
`include "pr_cfg.svh"
module pr_dram
	import pr_pkg::*;
(
	// Clock and reset
	input  wire logic   sys_clk,
	input  wire logic   rst,
	// Link to controller
	pr_if.dram          link,
	// Forwarded core commands
	output logic        core_valid,
	output pr_cmd_e     core_cmd,
	output logic [1:0]  core_bg,
	output logic [1:0]  core_ba,
	output logic [17:0] core_addr,
	// Status
	output logic        pattern_mode,
	output logic        cmd_refused
);
	// ****************************************************************
	// Command decode
	// ****************************************************************
	logic [12:0] mr3;
	logic [1:0]  mr0_bl;
	logic [2:0]  pl_cyc;
	logic [7:0]  exit_cnt;
	logic [31:0] pat;
	logic        is_mrs;
	logic [2:0]  mr_num;
	logic        pat_rd;
	logic        pat_wr;
	logic        in_exit;
	logic        core_op;
	logic        bc4;

	assign is_mrs  = link.cmd_valid && link.cmd == PR_MRS;
	assign mr_num  = {link.bg[0], link.ba};
	// Reads and writes go to the pattern store only while the mode bit is set
	assign pat_rd  = link.cmd_valid && link.cmd == PR_RD && mr3[`PR_MR3_MODE_BIT];
	assign pat_wr  = link.cmd_valid && link.cmd == PR_WR && mr3[`PR_MR3_MODE_BIT];
	assign in_exit = exit_cnt != 8'h00;
	assign core_op = link.cmd_valid && (link.cmd == PR_ACT || link.cmd == PR_RD
		|| link.cmd == PR_WR);
	// Chop when fixed BC4, or when on-the-fly and A12 is low
	assign bc4 = mr0_bl == `PR_BL_BC4
		|| (mr0_bl == `PR_BL_OTF && !link.addr[`PR_A12_BIT]);

	// Mode register 3 capture; only mode, page and format bits matter here
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mr3 <= `PR_MR3_RST;
		end else if (is_mrs && mr_num == `PR_MR3) begin
			mr3 <= link.addr[12:0];
		end
	end

	// Burst length field and parity latency
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mr0_bl <= 2'h0;
			pl_cyc <= 3'h0;
		end else if (is_mrs && mr_num == `PR_MR0) begin
			mr0_bl <= link.addr[`PR_MR0_BL_LSB +: 2];
		end else if (is_mrs && mr_num == `PR_MR5) begin
			pl_cyc <= link.addr[`PR_MR5_PL_LSB +: 3];
		end
	end

	// Exit delay: activates, reads and writes stay blocked until the mode command delay runs out; other commands still pass
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			exit_cnt <= 8'h00;
		end else if (is_mrs && mr_num == `PR_MR3 && mr3[`PR_MR3_MODE_BIT]
			&& !link.addr[`PR_MR3_MODE_BIT]) begin
			exit_cnt <= `PR_T_MOD_CYC;
		end else if (in_exit) begin
			exit_cnt <= exit_cnt - 8'h01;
		end
	end

	// Status flags
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pattern_mode <= 1'b0;
			cmd_refused  <= 1'b0;
		end else begin
			pattern_mode <= mr3[`PR_MR3_MODE_BIT];
			cmd_refused  <= core_op && in_exit;
		end
	end

	// ****************************************************************
	// Pattern store
	// ****************************************************************
	// Page 0 writes only; other pages are read-only here. BA picks the byte,
	// A10, BG and upper address are never looked at.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pat <= {4{`PR_PAT_RST}};
		end else if (pat_wr && mr3[`PR_MR3_PAGE_LSB +: 2] == `PR_PAGE0) begin
			pat[{link.ba, 3'h0} +: 8] <= link.addr[7:0];
		end
	end

	// ****************************************************************
	// Core forwarding
	// ****************************************************************
	// Anything not claimed by pattern mode or refused in the exit delay goes to the array; mode commands stay here
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			core_valid <= 1'b0;
			core_cmd   <= PR_NOP;
			core_bg    <= 2'h0;
			core_ba    <= 2'h0;
			core_addr  <= 18'h00000;
		end else begin
			core_valid <= link.cmd_valid && !is_mrs && !pat_rd && !pat_wr
				&& !(core_op && in_exit);
			core_cmd   <= link.cmd;
			core_bg    <= link.bg;
			core_ba    <= link.ba;
			core_addr  <= link.addr;
		end
	end

	// ****************************************************************
	// Read latency pipeline
	// ****************************************************************
	// A read enters at slot latency-1 and walks to slot 0; a fixed latency
	// per read keeps bursts of 8-cycle spaced reads touching each other.
	logic [3:0]                 lat;
	logic [`PR_PIPE_DEPTH-1:0]  pv;
	logic [1:0]                 ploc [`PR_PIPE_DEPTH];
	logic                       pbc4 [`PR_PIPE_DEPTH];
	logic                       ppg0 [`PR_PIPE_DEPTH];
	pr_fmt_e                    pfmt [`PR_PIPE_DEPTH];

	assign lat = `PR_READ_LAT + {1'b0, pl_cyc};

	// Slot shift with insertion
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pv <= '0;
			for (int i = 0; i < `PR_PIPE_DEPTH; i++) begin
				ploc[i] <= 2'h0;
				pbc4[i] <= 1'b0;
				ppg0[i] <= 1'b0;
				pfmt[i] <= PR_SERIAL;
			end
		end else begin
			for (int i = 0; i < `PR_PIPE_DEPTH; i++) begin
				if (pat_rd && 4'(i) == lat - 4'h1) begin
					pv[i]   <= 1'b1;
					ploc[i] <= link.ba;
					pbc4[i] <= bc4;
					ppg0[i] <= mr3[`PR_MR3_PAGE_LSB +: 2] == `PR_PAGE0;
					pfmt[i] <= pr_fmt_e'(mr3[`PR_MR3_FMT_LSB +: 2]);
				end else if (i < `PR_PIPE_DEPTH - 1) begin
					pv[i]   <= pv[i+1];
					ploc[i] <= ploc[i+1];
					pbc4[i] <= pbc4[i+1];
					ppg0[i] <= ppg0[i+1];
					pfmt[i] <= pfmt[i+1];
				end else begin
					pv[i] <= 1'b0;
				end
			end
		end
	end

	// ****************************************************************
	// Burst engine
	// ****************************************************************
	logic        b_act;
	logic [2:0]  b_beat;
	logic [1:0]  b_loc;
	logic        b_bc4;
	logic        b_pg0;
	pr_fmt_e     b_fmt;
	logic        start;
	logic [1:0]  cur_loc;
	logic [2:0]  cur_beat;
	logic        cur_bc4;
	logic        cur_pg0;
	pr_fmt_e     cur_fmt;
	logic [15:0] lanes;

	// A burst arriving at slot 0 takes over at once, so beat 7 of one read
	// is followed directly by beat 0 of the next
	assign start    = pv[0];
	assign cur_loc  = start ? ploc[0] : b_loc;
	assign cur_beat = start ? 3'h0 : b_beat;
	assign cur_bc4  = start ? pbc4[0] : b_bc4;
	assign cur_pg0  = start ? ppg0[0] : b_pg0;
	assign cur_fmt  = start ? pfmt[0] : b_fmt;

	pr_lane_map u_map (
		.loc   (cur_loc),
		.beat  (cur_beat),
		.fmt   (cur_fmt),
		.pat   (pat),
		.lanes (lanes)
	);

	// Beat counter
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			b_act  <= 1'b0;
			b_beat <= 3'h0;
			b_loc  <= 2'h0;
			b_bc4  <= 1'b0;
			b_pg0  <= 1'b0;
			b_fmt  <= PR_SERIAL;
		end else if (start) begin
			b_act  <= 1'b1;
			b_beat <= 3'h1;
			b_loc  <= ploc[0];
			b_bc4  <= pbc4[0];
			b_pg0  <= ppg0[0];
			b_fmt  <= pfmt[0];
		end else if (b_act) begin
			b_beat <= b_beat + 3'h1;
			b_act  <= b_beat != 3'h7;
		end
	end

	// Data out; chopped beats and pages other than 0 read as zero
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			link.dq_valid <= 1'b0;
			link.dq       <= 16'h0000;
		end else begin
			link.dq_valid <= start || b_act;
			link.dq       <= (cur_pg0 && !(cur_bc4 && cur_beat[2])) ? lanes : 16'h0000;
		end
	end
endmodule
`default_nettype wire

// *** hdl/pr_lane_map.sv ***
// Lane mapper: picks the bit each data lane carries for one beat
`default_nettype none
`include "pr_cfg.svh"
module pr_lane_map
	import pr_pkg::*;
(
	// Selection
	input  wire logic [1:0]              loc,
	input  wire logic [2:0]              beat,
	input  wire pr_fmt_e                 fmt,
	// Pattern bytes, location 0 in the low byte
	input  wire logic [31:0]             pat,
	// Lane values
	output logic      [`PR_LANES-1:0]    lanes
);
	// Bit b of location l
	function automatic logic pick(input logic [31:0] p, input logic [1:0] l,
		input logic [2:0] b);
		pick = p[{l, b}];
	endfunction

	// ****************************************************************
	// One mapper per lane
	// ****************************************************************
	for (genvar i = 0; i < `PR_LANES; i++) begin : g_lane
		localparam logic [1:0] OFS = 2'(i);
		localparam logic [2:0] BIT = 3'(i);
		logic [1:0] sloc;
		assign sloc = loc + OFS; // Wraps modulo four
		// Lane i: serial repeats, parallel spreads byte 0, stagger rotates
		always_comb begin
			case (fmt)
				PR_SERIAL:   lanes[i] = pick(pat, loc, beat);
				PR_PARALLEL: lanes[i] = pick(pat, 2'h0, BIT);
				PR_STAGGER:  lanes[i] = pick(pat, sloc, beat);
				default:     lanes[i] = 1'b0;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** tb/pr_link_monitor.sv ***
// Checker for the command and read data link between both ends
`default_nettype none
module pr_link_monitor
	import pr_pkg::*;
(
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        rst,
	// Command lines
	input wire logic        cmd_valid,
	input wire pr_cmd_e     cmd,
	input wire logic [1:0]  bg,
	input wire logic [1:0]  ba,
	input wire logic [17:0] addr,
	input wire logic        dbi_n,
	// Read data lines
	input wire logic [15:0] dq,
	input wire logic        dq_valid
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ****
	// Mirror of settings seen on the link
	// ****
	logic        mode;
	logic [1:0]  fmt;
	logic [1:0]  page;
	logic [1:0]  blf;
	logic [2:0]  pl;
	logic [15:0] rd_pipe;
	logic [3:0]  quiet;
	wire         mrs = cmd_valid && cmd == PR_MRS;
	wire         acc = cmd_valid && (cmd == PR_RD || cmd == PR_WR);
	wire         rd_pm = acc && cmd == PR_RD && mode;
	wire         start = rd_pipe[4'h4 + 4'(pl)];
	// Format and page follow entry only, so a late burst keeps its own format
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mode <= 1'b0;
			fmt <= 2'h0;
			page <= 2'h0;
			blf <= 2'h0;
			pl <= 3'h0;
		end else if (mrs) begin
			case ({bg[0], ba})
				3'h0: blf <= addr[1:0];
				3'h5: pl <= addr[2:0];
				3'h3: begin
					mode <= addr[2];
					if (addr[2]) begin
						fmt <= addr[12:11];
						page <= addr[1:0];
					end
				end
				default: ;
			endcase
		end
	end
	// Pipe of reads gives the burst start; quiet counts idle cycles, saturating
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rd_pipe <= 16'h0000;
			quiet <= 4'hf;
		end else begin
			rd_pipe <= {rd_pipe[14:0], rd_pm};
			quiet <= acc ? 4'h0 : (quiet == 4'hf ? quiet : quiet + 4'h1);
		end
	end
	// ****
	// Link checks
	// ****
	sequence pre_all_s;
		cmd_valid && cmd == PR_PRE && addr[10];
	endsequence
	sequence wr_s;
		acc && cmd == PR_WR;
	endsequence
	sequence exit_s;
		mrs && {bg[0], ba} == 3'h3 && !addr[2] && mode;
	endsequence
	rd_burst_a: assert property (start |-> dq_valid [*8])
		else $error("read burst late or broken");
	serial_lanes_a: assert property (dq_valid && fmt == PR_SERIAL
		|-> dq == {16{dq[0]}}) else $error("serial lanes differ");
	stagger_copy_a: assert property (dq_valid && fmt == PR_STAGGER
		|-> dq[15:8] == dq[7:0] && dq[7:4] == dq[3:0]) else $error("stagger not repeated");
	dbi_off_a: assert property (wr_s |-> dbi_n)
		else $error("inversion on a pattern write");
	rd_addr_a: assert property (rd_pm
		|-> addr[2:0] == 3'h0 && (blf != 2'h1 || addr[12]))
		else $error("pattern read address bits wrong");
	wr_page_a: assert property (wr_s |-> mode && page == 2'h0)
		else $error("write outside page zero");
	wr_recover_a: assert property (wr_s |=> (!acc) [*4])
		else $error("access inside write recovery");
	pre_wait_a: assert property (pre_all_s |=> (!cmd_valid) [*2])
		else $error("command inside row precharge time");
	exit_wait_a: assert property (exit_s |-> quiet >= 4'h2)
		else $error("exit too soon after access");
	exit_mod_a: assert property (exit_s |=> (!acc) [*3])
		else $error("access inside exit delay");
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Testbench joining controller and device ends of the pattern register link
`default_nettype none
module testbench
	import pr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {pr_fmt_e f; logic [1:0] bl; logic [2:0] pl;
		logic wr; logic [1:0] loc; logic [7:0] d;} pr_row_s;
	// ****
	// Harness
	// ****
	logic         sys_clk = 1'b0;
	logic         rst = 1'b1;
	logic         dll_locked;
	pr_fmt_e      req_fmt;
	logic [1:0]   bl_field;
	logic [2:0]   pl_code;
	logic         req_valid;
	logic         req_write;
	logic [1:0]   req_loc;
	logic [7:0]   req_data;
	logic         ref_req;
	logic         exit_req;
	logic         req_ready;
	logic         rd_valid;
	logic [127:0] rd_data;
	logic         busy;
	logic         pattern_mode;
	logic         core_valid;
	pr_cmd_e      core_cmd;
	int           n_core_acc = 0;
	int           n_core_ref = 0;
	logic [7:0]   pat [4];
	logic [127:0] got_q [$];
	logic [127:0] exp_q [$];
	int           n_fail = 0;
	int           n_compared = 0;
	pr_if         link ();
	pr_ctrl pr_ctrl_i (.sys_clk(sys_clk), .rst(rst), .link(link.ctrl), .dll_locked(dll_locked),
		.req_fmt(req_fmt), .bl_field(bl_field), .pl_code(pl_code), .req_valid(req_valid),
		.req_write(req_write), .req_loc(req_loc), .req_data(req_data), .ref_req(ref_req),
		.exit_req(exit_req), .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
		.busy(busy));
	pr_dram pr_dram_i (.sys_clk(sys_clk), .rst(rst), .link(link.dram), .core_valid(core_valid),
		.core_cmd(core_cmd), .core_bg(), .core_ba(), .core_addr(), .pattern_mode(pattern_mode),
		.cmd_refused());
	pr_link_monitor pr_link_monitor_i (.sys_clk(sys_clk), .rst(rst), .cmd_valid(link.cmd_valid),
		.cmd(link.cmd), .bg(link.bg), .ba(link.ba), .addr(link.addr), .dbi_n(link.dbi_n),
		.dq(link.dq), .dq_valid(link.dq_valid));
	// Session rows: format, burst field, parity latency, write, location, byte
	pr_row_s rows [13] = '{
		'{PR_STAGGER, 2'h0, 3'h0, 1'b1, 2'h0, 8'h17}, '{PR_STAGGER, 2'h0, 3'h0, 1'b1, 2'h1, 8'h2c},
		'{PR_STAGGER, 2'h0, 3'h0, 1'b1, 2'h2, 8'hd1}, '{PR_STAGGER, 2'h0, 3'h0, 1'b1, 2'h3, 8'h8e},
		'{PR_STAGGER, 2'h0, 3'h0, 1'b0, 2'h0, 8'h00}, '{PR_STAGGER, 2'h0, 3'h0, 1'b0, 2'h1, 8'h00},
		'{PR_STAGGER, 2'h0, 3'h0, 1'b0, 2'h2, 8'h00}, '{PR_STAGGER, 2'h0, 3'h0, 1'b0, 2'h3, 8'h00},
		'{PR_SERIAL, 2'h2, 3'h2, 1'b0, 2'h1, 8'h00}, '{PR_SERIAL, 2'h2, 3'h2, 1'b0, 2'h3, 8'h00},
		'{PR_PARALLEL, 2'h1, 3'h5, 1'b1, 2'h0, 8'h6b}, '{PR_PARALLEL, 2'h1, 3'h5, 1'b0, 2'h0, 8'h00},
		'{PR_FMT_RFU, 2'h0, 3'h0, 1'b0, 2'h2, 8'h00}};
	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;
	// Collect returns so reads can be issued back to back
	always @(posedge sys_clk)
		if (rd_valid === 1'b1)
			got_q.push_back(rd_data);
	// Count what reaches the array; pattern reads and writes must never get there
	always @(posedge sys_clk)
		if (core_valid === 1'b1) begin
			n_core_acc += (core_cmd == PR_RD || core_cmd == PR_WR) ? 1 : 0;
			n_core_ref += (core_cmd == PR_REF) ? 1 : 0;
		end
	// Expected burst image; chop-4 leaves the last four beats zero
	function automatic logic [127:0] expect_rd(pr_fmt_e f, logic [1:0] bl, logic [1:0] k);
		logic [127:0] r;
		r = '0;
		for (int b = 0; b < 8; b++)
			for (int i = 0; i < 16; i++)
				case (f)
					PR_SERIAL: r[16 * b + i] = pat[k][b];
					PR_PARALLEL: r[16 * b + i] = pat[0][i % 8];
					PR_STAGGER: r[16 * b + i] = pat[(k + i) % 4][b];
					default: r[16 * b + i] = 1'b0;
				endcase
		if (bl == 2'h2)
			r[127:64] = '0;
		return r;
	endfunction
	task automatic chk_data(input logic [127:0] got, input logic [127:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: read %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_flag(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Bounded wait: 0 request taken, 1 idle, 2 all reads back; a hang ends the run
	task automatic wait_sig(input int w);
		int n;
		n = 0;
		while (!(w == 0 ? req_ready === 1'b1 : w == 1 ? busy === 1'b0
				: got_q.size() == exp_q.size())) begin
			@(posedge sys_clk);
			#1;
			n++;
			if (n > 300) begin
				n_fail++;
				$display("wrong value at %0t: wait %0d timed out", $time, w);
				summarize();
			end
		end
	endtask
	// One request, held until taken; the expected image is fixed when the read is taken
	task automatic access(input pr_row_s r);
		req_fmt = r.f;
		bl_field = r.bl;
		pl_code = r.pl;
		req_write = r.wr;
		req_loc = r.loc;
		req_data = r.d;
		req_valid = 1'b1;
		wait_sig(0);
		req_valid = 1'b0;
		// Let the one-cycle ready pulse end, or the next call takes it as its own
		@(posedge sys_clk);
		#1;
		if (r.wr)
			pat[r.loc] = r.d;
		else
			exp_q.push_back(expect_rd(r.f, r.bl, r.loc));
	endtask
	// Compare returned reads, then leave pattern mode
	task automatic leave();
		wait_sig(2);
		while (exp_q.size() > 0)
			chk_data(got_q.pop_front(), exp_q.pop_front());
		exit_req = 1'b1;
		wait_sig(1);
		exit_req = 1'b0;
		chk_flag(pattern_mode, 1'b0);
	endtask
	// ****
	// Scenarios
	// ****
	initial begin
		{dll_locked, req_valid, ref_req, exit_req} = '0;
		{req_write, req_loc, req_data, bl_field, pl_code} = '0;
		req_fmt = PR_SERIAL;
		foreach (pat[i]) pat[i] = 8'h00;
		repeat (10) @(posedge sys_clk);
		#1;
		chk_flag(busy, 1'b0);
		rst = 1'b0;
		// No session may start while the lock is missing
		req_valid = 1'b1;
		repeat (20) @(posedge sys_clk);
		#1;
		chk_flag(pattern_mode, 1'b0);
		dll_locked = 1'b1;
		foreach (rows[r]) begin
			if (r > 0 && rows[r].f != rows[r - 1].f)
				leave();
			access(rows[r]);
		end
		leave();
		// Refresh between back-to-back reads; bytes survive earlier exits
		access(rows[4]);
		ref_req = 1'b1;
		@(posedge sys_clk);
		#1;
		ref_req = 1'b0;
		access(rows[6]);
		leave();
		chk_flag(n_core_ref == 1, 1'b1);
		// Reset in mid-session clears mode and stored bytes
		access(rows[5]);
		rst = 1'b1;
		@(posedge sys_clk);
		#1;
		chk_flag(pattern_mode, 1'b0);
		rst = 1'b0;
		foreach (pat[i]) pat[i] = 8'h00;
		got_q.delete();
		exp_q.delete();
		access(rows[7]);
		leave();
		chk_flag(n_core_acc == 0, 1'b1);
		summarize();
	end
endmodule
`default_nettype wire
